// ---- core/rcadc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Counter A is 24 bits; low word at first register, bits 23..16 low byte.
// - Counter B is 24 bits; low word at first register, bits 23..16 low byte.
// - While running after a write, reading returns the written value.
// - After the run bit clears, reading returns the accumulated count.
// - All six registers reset to zero; high bytes take byte access only.
// - Sensor is measured by counting the RC oscillator clock.
// - Two channels share the counters, one selected per conversion.
// - Channel 0 and channel 1 input pins feed counter B's clock.
// - Monitor output mirrors the oscillation waveform when its pin is enabled and the run bit is set.
// - Run bit starts/stops; cleared on either overflow and by reset.
// - Interrupt on counter A overflow if source bit zero, else counter B.
// - A counts base clock, B oscillator clock; each flags overflow past max.
// - Three-bit field picks low-speed clock, system clock, or it divided.
module rcadc_top
   import rcadc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic [15:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr_lo,
   input  wire logic        wr_hi,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        low_speed_clk,
   input  wire logic        sys_osc_clk,
   input  wire logic        channel0_osc_input,
   input  wire logic        channel1_osc_input,
   input  wire logic        monitor_pin_enable,
   output logic             oscillation_monitor_out,
   output logic             conversion_irq,
   output logic             timebase_overflow_flag,
   output logic             oscillation_overflow_flag
);
   import rcadc_pkg::*;

   logic             rst_s1_r, rst_n;
   logic [CNT_W-1:0] cnt_a_r, cnt_b_r;
   logic [CNT_W-1:0] shadow_a_r, shadow_b_r;
   logic             wrote_a_r, wrote_b_r;
   logic [15:0]      mode_r, ctrl_r;
   logic [DIV_W-1:0] div_r;
   logic             run;
   logic [3:0]       osc_mode;
   logic [2:0]       clk_sel;
   logic             irq_src;
   logic             osc_clk, base_clk, osc_tick, base_tick;
   logic             ovf_a, ovf_b;
   logic             sel_lo, sel_hi;
   rcadc_state_type  state_r;

   // Reset release synchroniser
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   assign run      = ctrl_r[POS_RUN];
   assign osc_mode = mode_r[POS_OM +: 4];
   assign irq_src  = mode_r[POS_IRQ_SRC];
   assign clk_sel  = mode_r[POS_CLK_SEL +: 3];
   assign sel_lo   = wr_lo;
   assign sel_hi   = wr_hi;

   // Channel pick: modes 5..15 use channel 1, the rest channel 0
   assign osc_clk = (osc_mode >= OM_CH1_FIRST) ? channel1_osc_input
                                               : channel0_osc_input;
   // Monitor gated by the run bit, so it is quiet when stopped
   assign oscillation_monitor_out = monitor_pin_enable & run & osc_clk;

   // Base clock prescaler runs free on the system oscillator edges
   logic sys_tick;
   rcadc_edge u_sys_edge (.clk(clk), .rst_n(rst_n), .level(sys_osc_clk), .rise(sys_tick));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= '0;
      end else if (sys_tick) begin
         div_r <= div_r + 1'b1;
      end
   end

   always_comb begin
      case (clk_sel)
         3'h0:    base_clk = low_speed_clk;
         3'h1:    base_clk = sys_osc_clk;
         default: base_clk = div_r[clk_sel - 3'h2];
      endcase
   end

   rcadc_edge u_base_edge (.clk(clk), .rst_n(rst_n), .level(base_clk), .rise(base_tick));
   rcadc_edge u_osc_edge  (.clk(clk), .rst_n(rst_n), .level(osc_clk), .rise(osc_tick));

   assign ovf_a = run & base_tick & (cnt_a_r == CNT_MAX);
   assign ovf_b = run & osc_tick & (cnt_b_r == CNT_MAX);

   // Counter A
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_a_r <= {8'h00, REG_RESET};
      end else if (sel_lo && addr == OFS_CNT_A_LO) begin
         cnt_a_r[15:0] <= wdata;
      end else if (sel_hi && addr == OFS_CNT_A_LO + 16'h0001) begin
         cnt_a_r[15:8] <= wdata[15:8];
      end else if (sel_lo && addr == OFS_CNT_A_HI) begin
         cnt_a_r[23:16] <= wdata[7:0];
      end else if (run && base_tick) begin
         cnt_a_r <= cnt_a_r + 24'h000001;
      end
   end

   // Counter B
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_b_r <= {8'h00, REG_RESET};
      end else if (sel_lo && addr == OFS_CNT_B_LO) begin
         cnt_b_r[15:0] <= wdata;
      end else if (sel_hi && addr == OFS_CNT_B_LO + 16'h0001) begin
         cnt_b_r[15:8] <= wdata[15:8];
      end else if (sel_lo && addr == OFS_CNT_B_HI) begin
         cnt_b_r[23:16] <= wdata[7:0];
      end else if (run && osc_tick) begin
         cnt_b_r <= cnt_b_r + 24'h000001;
      end
   end

   // Shadow of last written values, shown while running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_a_r <= '0;
         shadow_b_r <= '0;
         wrote_a_r  <= 1'b0;
         wrote_b_r  <= 1'b0;
      end else begin
         if (sel_lo && addr == OFS_CNT_A_LO) begin
            shadow_a_r[15:0] <= wdata;
            wrote_a_r        <= 1'b1;
         end else if (sel_hi && addr == OFS_CNT_A_LO + 16'h0001) begin
            shadow_a_r[15:8] <= wdata[15:8];
            wrote_a_r        <= 1'b1;
         end else if (sel_lo && addr == OFS_CNT_A_HI) begin
            shadow_a_r[23:16] <= wdata[7:0];
            wrote_a_r         <= 1'b1;
         end else if (state_r == RCADC_RUN && !run) begin
            // Kept until the run ends, so a write made before start still shows
            wrote_a_r <= 1'b0;
         end
         if (sel_lo && addr == OFS_CNT_B_LO) begin
            shadow_b_r[15:0] <= wdata;
            wrote_b_r        <= 1'b1;
         end else if (sel_hi && addr == OFS_CNT_B_LO + 16'h0001) begin
            shadow_b_r[15:8] <= wdata[15:8];
            wrote_b_r        <= 1'b1;
         end else if (sel_lo && addr == OFS_CNT_B_HI) begin
            shadow_b_r[23:16] <= wdata[7:0];
            wrote_b_r         <= 1'b1;
         end else if (state_r == RCADC_RUN && !run) begin
            wrote_b_r <= 1'b0;
         end
      end
   end

   // Mode register; high byte reserved reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= REG_RESET;
      end else if (sel_lo && addr == OFS_MODE) begin
         mode_r[7:0] <= wdata[7:0];
      end
   end

   // Run bit; overflow clear beats a software set in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= REG_RESET;
      end else if (ovf_a || ovf_b) begin
         ctrl_r[POS_RUN] <= 1'b0;
      end else if (sel_lo && addr == OFS_CTRL) begin
         ctrl_r[POS_RUN] <= wdata[POS_RUN];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= RCADC_IDLE;
      end else begin
         case (state_r)
            RCADC_IDLE: state_r <= run ? RCADC_RUN : RCADC_IDLE;
            RCADC_RUN:  state_r <= run ? RCADC_RUN : RCADC_IDLE;
            default:    state_r <= RCADC_IDLE;
         endcase
      end
   end

   // Sticky overflow flags, cleared when a new run starts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timebase_overflow_flag    <= 1'b0;
         oscillation_overflow_flag <= 1'b0;
         conversion_irq            <= 1'b0;
      end else begin
         if (ovf_a) begin
            timebase_overflow_flag <= 1'b1;
         end else if (state_r == RCADC_IDLE && run) begin
            timebase_overflow_flag <= 1'b0;
         end
         if (ovf_b) begin
            oscillation_overflow_flag <= 1'b1;
         end else if (state_r == RCADC_IDLE && run) begin
            oscillation_overflow_flag <= 1'b0;
         end
         conversion_irq <= irq_src ? ovf_b : ovf_a;
      end
   end

   // Read mux, registered; shadow shown while running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= REG_RESET;
      end else if (rd) begin
         case (addr)
            OFS_CNT_A_LO: rdata <= (run && wrote_a_r) ? shadow_a_r[15:0] : cnt_a_r[15:0];
            OFS_CNT_A_HI: rdata <= {8'h00, (run && wrote_a_r) ? shadow_a_r[23:16]
                                                              : cnt_a_r[23:16]};
            OFS_CNT_B_LO: rdata <= (run && wrote_b_r) ? shadow_b_r[15:0] : cnt_b_r[15:0];
            OFS_CNT_B_HI: rdata <= {8'h00, (run && wrote_b_r) ? shadow_b_r[23:16]
                                                              : cnt_b_r[23:16]};
            OFS_MODE:     rdata <= mode_r;
            OFS_CTRL:     rdata <= ctrl_r;
            default:      rdata <= 16'h0000;
         endcase
      end
   end

   a_run_clear_ovf: assert property (@(posedge clk) disable iff (!rst_n)
      (ovf_a || ovf_b) |=> !run) else $error("run bit not cleared on overflow");
   a_irq_src_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ovf_a && !irq_src) |=> conversion_irq) else $error("missing irq on A");
   a_irq_src_b: assert property (@(posedge clk) disable iff (!rst_n)
      (ovf_b && irq_src) |=> conversion_irq) else $error("missing irq on B");
   a_cnt_a_inc: assert property (@(posedge clk) disable iff (!rst_n)
      (run && base_tick && !sel_lo && !sel_hi) |=> cnt_a_r == $past(cnt_a_r) + 24'h000001)
      else $error("counter A did not advance");
   a_cnt_b_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (!run && !sel_lo && !sel_hi) |=> $stable(cnt_b_r)) else $error("B moved while stopped");
   a_cnt_a_load: assert property (@(posedge clk) disable iff (!rst_n)
      (sel_lo && addr == OFS_CNT_A_LO) |=> cnt_a_r[15:0] == $past(wdata))
      else $error("counter A load lost");
   a_rd_shadow: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && addr == OFS_CNT_B_LO && run && wrote_b_r) |=> rdata == $past(shadow_b_r[15:0]))
      else $error("read did not show written value");
   a_rd_count: assert property (@(posedge clk) disable iff (!rst_n)
      (rd && addr == OFS_CNT_A_LO && !run) |=> rdata == $past(cnt_a_r[15:0]))
      else $error("read did not show count");
   a_mon_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      !monitor_pin_enable |-> !oscillation_monitor_out) else $error("monitor leaked");
   c_run_start: cover property (@(posedge clk) disable iff (!rst_n) $rose(run));
   c_ovf_a:     cover property (@(posedge clk) disable iff (!rst_n) ovf_a);
   c_ovf_b:     cover property (@(posedge clk) disable iff (!rst_n) ovf_b);
endmodule
`default_nettype wire

// ---- core/rcadc_pkg.sv ----
package rcadc_pkg;
   localparam logic [15:0] OFS_CNT_A_LO  = 16'hf800;
   localparam logic [15:0] OFS_CNT_A_HI  = 16'hf802;
   localparam logic [15:0] OFS_CNT_B_LO  = 16'hf804;
   localparam logic [15:0] OFS_CNT_B_HI  = 16'hf806;
   localparam logic [15:0] OFS_MODE      = 16'hf808;
   localparam logic [15:0] OFS_CTRL      = 16'hf80a;
   localparam logic [15:0] REG_RESET     = 16'h0000;
   localparam int          CNT_W         = 24;
   localparam logic [23:0] CNT_MAX       = 24'hffffff;
   localparam int          POS_OM        = 0;
   localparam int          POS_IRQ_SRC   = 4;
   localparam int          POS_CLK_SEL   = 5;
   localparam int          POS_RUN       = 0;
   localparam logic [3:0]  OM_IN1_EXT    = 4'h7;
   localparam logic [3:0]  OM_CH1_FIRST  = 4'h5;
   localparam int          DIV_W         = 6;
   typedef enum logic [1:0] {RCADC_IDLE, RCADC_RUN} rcadc_state_type;
endpackage

// ---- core/rcadc_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
// Rising-edge detector for a clock-like level sampled on clk
module rcadc_edge (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic level,
   output logic      rise
);
   logic prev_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= level;
      end
   end
   assign rise = level & ~prev_r;
endmodule
`default_nettype wire

// ---- tb/rcadc_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two RC oscillators; each runs only while its enable is high
module rcadc_osc_model #(
   parameter int HALF0 = 3,
   parameter int HALF1 = 5
) (
   input  wire logic       clk,
   input  wire logic [1:0] osc_on,
   output logic            channel0_osc_input,
   output logic            channel1_osc_input
);
   int   cnt0 = 0;
   int   cnt1 = 0;
   logic q0   = 1'b0;
   logic q1   = 1'b0;
   assign channel0_osc_input = q0;
   assign channel1_osc_input = q1;
   // Stopped oscillator rests low, never at its last level
   always @(negedge clk) begin
      cnt0 <= (!osc_on[0] || cnt0 == HALF0 - 1) ? 0 : cnt0 + 1;
      q0   <= !osc_on[0] ? 1'b0 : (cnt0 == HALF0 - 1) ? ~q0 : q0;
      cnt1 <= (!osc_on[1] || cnt1 == HALF1 - 1) ? 0 : cnt1 + 1;
      q1   <= !osc_on[1] ? 1'b0 : (cnt1 == HALF1 - 1) ? ~q1 : q1;
   end
endmodule
`default_nettype wire

// ---- tb/rcadc_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcadc_tb_top;
   import rcadc_pkg::*;
   logic        clk;
   logic        nrst = 1'b0;
   logic [15:0] addr = 16'h0;
   logic [15:0] wdata = 16'h0;
   logic        wr_lo = 1'b0;
   logic        wr_hi = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] rdata;
   logic        low_speed_clk = 1'b0;
   logic        sys_osc_clk = 1'b0;
   logic [2:0]  lsc_div = 3'h0;
   logic        ch0;
   logic        ch1;
   logic [1:0]  osc_on = 2'h0;
   logic        monitor_pin_enable = 1'b0;
   logic        mon_out;
   logic        mon_q = 1'b0;
   logic        irq;
   logic        flag_a;
   logic        flag_b;
   logic [15:0] rv;
   int          mon_cnt = 0;
   int          mon_base;
   int          cycles = 0;
   int          bad_count = 0;
   int          num_checks = 0;

   rcadc_top uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_lo(wr_lo),
      .wr_hi(wr_hi), .rd(rd), .rdata(rdata), .low_speed_clk(low_speed_clk),
      .sys_osc_clk(sys_osc_clk), .channel0_osc_input(ch0), .channel1_osc_input(ch1),
      .monitor_pin_enable(monitor_pin_enable), .oscillation_monitor_out(mon_out),
      .conversion_irq(irq), .timebase_overflow_flag(flag_a),
      .oscillation_overflow_flag(flag_b));
   rcadc_osc_model osc (.clk(clk), .osc_on(osc_on), .channel0_osc_input(ch0),
      .channel1_osc_input(ch1));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Base clocks at half the clk rate or slower so every edge is seen
   always @(negedge clk) begin
      sys_osc_clk <= ~sys_osc_clk;
      lsc_div <= lsc_div + 3'h1;
      low_speed_clk <= lsc_div[2];
   end
   always @(posedge clk) begin
      mon_q <= mon_out;
      if (mon_out && !mon_q) begin
         mon_cnt <= mon_cnt + 1;
      end
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic hi);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr_lo = ~hi;
      wr_hi = hi;
      @(negedge clk);
      wr_lo = 1'b0;
      wr_hi = 1'b0;
   endtask
   task automatic rdget(input logic [15:0] a);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      rv = rdata;
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
      rdget(a);
      chk($sformatf("reg %h", a), e, rv);
   endtask
   // Counter is split over its low word and the next register's low byte
   task automatic load(input logic [15:0] a, input logic [23:0] v);
      wr(a, v[15:0], 1'b0);
      wr(a + 16'h2, {8'h0, v[23:16]}, 1'b0);
   endtask
   task automatic wait_irq(input int n, input logic e);
      logic seen = 1'b0;
      for (int i = 0; i < n && !seen; i++) begin
         @(negedge clk);
         seen = (irq === 1'b1);
      end
      chk("irq", {15'h0, e}, {15'h0, seen});
   endtask

   initial begin
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 6; i++) begin
         rdchk(OFS_CNT_A_LO + 16'(2 * i), REG_RESET);
      end
      rdchk(16'hf80c, 16'h0000);
      wr(OFS_CNT_A_LO, 16'h1234, 1'b0);
      wr(OFS_CNT_A_LO + 16'h1, 16'hab00, 1'b1);
      wr(OFS_CNT_A_HI, 16'h0056, 1'b0);
      wr(OFS_MODE + 16'h1, 16'hff00, 1'b1);
      rdchk(OFS_CNT_A_LO, 16'hab34);
      rdchk(OFS_CNT_A_HI, 16'h0056);
      rdchk(OFS_MODE, 16'h0000);
      // Counter B overflow drives the request, monitor pin on
      wr(OFS_MODE, 16'h0030, 1'b0);
      load(OFS_CNT_B_LO, CNT_MAX - 24'd2);
      load(OFS_CNT_A_LO, 24'h0);
      monitor_pin_enable = 1'b1;
      osc_on = 2'b01;
      wr(OFS_CTRL, 16'h0001, 1'b0);
      rdchk(OFS_CNT_B_LO, 16'hfffd);
      wait_irq(400, 1'b1);
      chk("ovf_b", 16'h1, {15'h0, flag_b});
      chk("ovf_a", 16'h0, {15'h0, flag_a});
      chk("monitor", 16'h1, {15'h0, mon_cnt > 0});
      rdchk(OFS_CTRL, 16'h0000);
      rdchk(OFS_CNT_A_HI, 16'h0000);
      rdget(OFS_CNT_A_LO);
      // Base clock rises every two cycles against three oscillator rises
      chk("a_count", 16'h1, {15'h0, rv >= 16'd4 && rv <= 16'd10});
      // Every base clock code, counter A overflow as source
      monitor_pin_enable = 1'b0;
      mon_base = mon_cnt;
      load(OFS_CNT_B_LO, 24'h0);
      for (int c = 0; c < 8; c++) begin
         wr(OFS_MODE, 16'(c << POS_CLK_SEL), 1'b0);
         load(OFS_CNT_A_LO, CNT_MAX);
         wr(OFS_CTRL, 16'h0001, 1'b0);
         wait_irq(400, 1'b1);
         chk("ovf_a", 16'h1, {15'h0, flag_a});
         chk("ovf_b", 16'h0, {15'h0, flag_b});
      end
      chk("monitor_off", 16'h0, 16'(mon_cnt - mon_base));
      // Channel 1 mode ignores channel 0 activity
      osc_on = 2'b01;
      wr(OFS_MODE, {8'h0, 3'b001, 1'b1, OM_CH1_FIRST}, 1'b0);
      load(OFS_CNT_B_LO, CNT_MAX);
      load(OFS_CNT_A_LO, 24'h0);
      wr(OFS_CTRL, 16'h0001, 1'b0);
      wait_irq(200, 1'b0);
      osc_on = 2'b11;
      wait_irq(400, 1'b1);
      // Software stop keeps the accumulated count
      wr(OFS_MODE, 16'h0030, 1'b0);
      load(OFS_CNT_B_LO, 24'h0);
      wr(OFS_CTRL, 16'h0001, 1'b0);
      wait_irq(100, 1'b0);
      rdchk(OFS_CNT_B_LO, 16'h0000);
      wr(OFS_CTRL, 16'h0000, 1'b0);
      rdchk(OFS_CTRL, 16'h0000);
      rdchk(OFS_CNT_B_HI, 16'h0000);
      rdget(OFS_CNT_B_LO);
      // About a hundred cycles of run at one rise every six cycles
      chk("b_count", 16'h1, {15'h0, rv >= 16'd12 && rv <= 16'd22});
      // Reset in mid-run stops conversion and clears the registers
      wr(OFS_CTRL, 16'h0001, 1'b0);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      rdchk(OFS_CTRL, 16'h0000);
      rdchk(OFS_CNT_B_LO, 16'h0000);
      final_report();
   end
endmodule
`default_nettype wire
